// [shared/srse_pkg.sv]
// Package: encodings, field positions, flag layout and cycle phases
package srse_pkg;

  // Opcode encodings (upper six bits of the 16-bit instruction word; push is the whole word)
  localparam logic [15:0] SRSE_OP_PUSH = 16'h0005;
  localparam logic [5:0] SRSE_OP_RLNC = 6'h11;   // 0100 01da
  localparam logic [5:0] SRSE_OP_RRC = 6'h0C;    // 0011 00da
  localparam logic [5:0] SRSE_OP_SUBB = 6'h16;   // 0101 10da

  // Instruction word fields
  localparam int SRSE_OP_LSB = 10;
  localparam int SRSE_D_BIT = 9;
  localparam int SRSE_A_BIT = 8;

  // Status flag positions
  localparam int SRSE_FLG_C = 0;
  localparam int SRSE_FLG_DC = 1;
  localparam int SRSE_FLG_Z = 2;
  localparam int SRSE_FLG_OV = 3;
  localparam int SRSE_FLG_N = 4;

  // Addressing
  localparam logic [7:0] SRSE_IDX_LIMIT = 8'h5F;
  localparam logic [3:0] SRSE_ACC_HI_BANK = 4'hF;
  localparam logic [7:0] SRSE_ACC_SPLIT = 8'h60;

  // Increment of the program counter on a push
  localparam logic [20:0] SRSE_PC_STEP = 21'h00_0002;

  // Return stack
  localparam int SRSE_STK_DEPTH = 31;
  localparam int SRSE_STK_AW = 5;

  // Reset values
  localparam logic [7:0] SRSE_RST_W = 8'h00;
  localparam logic [4:0] SRSE_RST_FLAGS = 5'h00;
  localparam logic [4:0] SRSE_RST_PTR = 5'h00;

  typedef enum logic [1:0] {
    SRSE_Q1 = 2'b00,
    SRSE_Q2 = 2'b01,
    SRSE_Q3 = 2'b11,
    SRSE_Q4 = 2'b10
  } srse_phase_t;

  typedef enum logic [2:0] {
    SRSE_K_NONE,
    SRSE_K_PUSH,
    SRSE_K_RLNC,
    SRSE_K_RRC,
    SRSE_K_SUBB
  } srse_kind_t;

  // File-register access request toward the data memory
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } srse_fmem_t;

endpackage : srse_pkg

// [logic/srse_stack.sv]
// Hardware return stack with registered top-of-stack output
module srse_stack
  import srse_pkg::*;
(
  input  wire logic        clk_i,    // Core clock
  input  wire logic        nrst_i,   // Async reset, active low
  input  wire logic        push_i,   // Push strobe
  input  wire logic [20:0] data_i,   // Value pushed
  output logic [20:0]      top_o,    // Top of return stack
  output logic [4:0]       level_o   // Current depth
);

  logic [20:0] mem_ff [SRSE_STK_DEPTH];
  logic [4:0] ptr_ff;
  logic [20:0] top_ff;

  // ==========================================================
  // Storage: earlier entries stay put, so the old top sits one
  // level down once the pointer advances
  always_ff @(posedge clk_i) begin
    // A full stack keeps its entries; no write past the last slot
    if (push_i && (ptr_ff != 5'(SRSE_STK_DEPTH))) begin
      mem_ff[ptr_ff] <= data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_ff <= SRSE_RST_PTR;
      top_ff <= '0;
    end else if (push_i) begin
      // Saturates at full depth; overflow reporting is not kept here
      if (ptr_ff != 5'(SRSE_STK_DEPTH)) begin
        ptr_ff <= ptr_ff + 5'h01;
      end
      top_ff <= data_i;
    end
  end

  assign top_o = top_ff;
  assign level_o = ptr_ff;

endmodule // srse_stack

// [logic/srse_exec.sv]
// Execution unit: push, rotate left, rotate right through carry, sub-borrow
// ==========================================================
// Overview of operation
// - Push writes program counter plus two onto top of return stack.
// - Push moves old top one level deeper; flags unchanged.
// - Rotate left moves bit 7 into bit 0; only N and Z change.
// - Subtract with borrow: f minus W minus inverted carry; five flags.
// - Destination bit 0 writes W; bit 1 writes back the file register.
// - Access bit 0 selects access bank; 1 uses bank select register.
// - Extended set, access bit 0, address up to 5Fh: indexed offset.
module srse_exec
  import srse_pkg::*;
(
  input  wire logic        clk_i,       // Core clock
  input  wire logic        nrst_i,      // Async reset, active low
  input  wire logic        ins_vld_i,   // Instruction word valid at Q1
  input  wire logic [15:0] ins_i,       // Instruction word
  input  wire logic [20:0] pc_i,        // Address of this instruction
  input  wire logic [3:0]  bank_select_register_i, // Bank select
  input  wire logic        ext_set_i,   // Extended instruction set on
  input  wire logic [11:0] fsr2_i,      // Index base for offset mode
  input  wire logic [7:0]  frd_i,       // File read data, valid at Q3
  output srse_fmem_t       fmem_o,      // File memory request
  output logic [7:0]       w_o,         // Working accumulator
  output logic [4:0]       flags_o,     // N OV Z DC C
  output logic [20:0]      top_of_return_stack_o, // Stack top
  output logic [4:0]       stk_level_o, // Stack depth
  output srse_phase_t      phase_o,     // Current Q phase
  output logic             done_o       // Instruction retired pulse
);

  srse_phase_t phase_ff;
  srse_kind_t kind_ff;
  logic [15:0] ins_ff;
  logic [20:0] pc_ff;
  logic [7:0] w_ff;
  logic [4:0] flg_ff;
  logic [7:0] opnd_ff;
  srse_fmem_t fm_ff;
  logic done_ff;
  logic [11:0] addr;
  logic [7:0] f8;
  logic dbit;
  logic abit;
  srse_kind_t kind_dec;
  logic [7:0] nxt_res;
  logic [4:0] nxt_flg;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] nw;
  logic stk_push;

  // ==========================================================
  // Decode
  always_comb begin
    kind_dec = SRSE_K_NONE;
    if (ins_i == SRSE_OP_PUSH) begin
      kind_dec = SRSE_K_PUSH;
    end else if (ins_i[15:SRSE_OP_LSB] == SRSE_OP_RLNC) begin
      kind_dec = SRSE_K_RLNC;
    end else if (ins_i[15:SRSE_OP_LSB] == SRSE_OP_RRC) begin
      kind_dec = SRSE_K_RRC;
    end else if (ins_i[15:SRSE_OP_LSB] == SRSE_OP_SUBB) begin
      kind_dec = SRSE_K_SUBB;
    end
  end

  // The read leaves at the Q1 edge, before the word reaches ins_ff,
  // so in Q1 the operand address comes from the word being taken
  assign f8 = (phase_ff == SRSE_Q1) ? ins_i[7:0] : ins_ff[7:0];
  assign dbit = ins_ff[SRSE_D_BIT];
  assign abit = (phase_ff == SRSE_Q1) ? ins_i[SRSE_A_BIT]
                                      : ins_ff[SRSE_A_BIT];

  // ==========================================================
  // Operand address
  always_comb begin
    if (abit) begin
      addr = {bank_select_register_i, f8};
    end else if (ext_set_i && (f8 <= SRSE_IDX_LIMIT)) begin
      addr = fsr2_i + {4'h0, f8};
    end else if (f8 < SRSE_ACC_SPLIT) begin
      addr = {4'h0, f8};
    end else begin
      addr = {SRSE_ACC_HI_BANK, f8};
    end
  end

  // ==========================================================
  // Four-phase sequencer; idles in Q1 without a valid word
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_ff <= SRSE_Q1;
    end else begin
      unique case (phase_ff)
        SRSE_Q1: if (ins_vld_i) phase_ff <= SRSE_Q2;
        SRSE_Q2: phase_ff <= SRSE_Q3;
        SRSE_Q3: phase_ff <= SRSE_Q4;
        SRSE_Q4: phase_ff <= SRSE_Q1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      kind_ff <= SRSE_K_NONE;
      ins_ff <= '0;
      pc_ff <= '0;
    end else if (phase_ff == SRSE_Q1 && ins_vld_i) begin
      kind_ff <= kind_dec;
      ins_ff <= ins_i;
      pc_ff <= pc_i;
    end
  end

  // Push happens in Q2 only
  assign stk_push = (phase_ff == SRSE_Q2) && (kind_ff == SRSE_K_PUSH);

  // ==========================================================
  // Operand capture in Q3, from the read issued in Q2
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      opnd_ff <= '0;
    end else if (phase_ff == SRSE_Q3) begin
      opnd_ff <= frd_i;
    end
  end

  // ==========================================================
  // Arithmetic
  assign sum9 = {1'b0, opnd_ff} + {1'b0, ~w_ff} + {8'h00, flg_ff[SRSE_FLG_C]};
  assign sum5 = {1'b0, opnd_ff[3:0]} + {1'b0, ~w_ff[3:0]}
              + {4'h0, flg_ff[SRSE_FLG_C]};

  always_comb begin
    nxt_res = opnd_ff;
    nxt_flg = flg_ff;
    unique case (kind_ff)
      SRSE_K_RLNC: begin
        nxt_res = {opnd_ff[6:0], opnd_ff[7]};
      end
      SRSE_K_RRC: begin
        nxt_res = {flg_ff[SRSE_FLG_C], opnd_ff[7:1]};
        nxt_flg[SRSE_FLG_C] = opnd_ff[0];
      end
      SRSE_K_SUBB: begin
        // f + ~W + C equals f - W - ~C; carry set means no borrow
        nxt_res = sum9[7:0];
        nxt_flg[SRSE_FLG_C] = sum9[8];
        nxt_flg[SRSE_FLG_DC] = sum5[4];
        nxt_flg[SRSE_FLG_OV] = (opnd_ff[7] != w_ff[7])
                             && (sum9[7] != opnd_ff[7]);
      end
      default: begin
      end
    endcase
    if (kind_ff == SRSE_K_RLNC || kind_ff == SRSE_K_RRC
        || kind_ff == SRSE_K_SUBB) begin
      nxt_flg[SRSE_FLG_Z] = (nxt_res == 8'h00);
      nxt_flg[SRSE_FLG_N] = nxt_res[7];
    end
  end

  // ==========================================================
  // Destination write at end of Q4
  logic alu_op;
  assign alu_op = (kind_ff == SRSE_K_RLNC) || (kind_ff == SRSE_K_RRC)
               || (kind_ff == SRSE_K_SUBB);

  always_comb begin
    nw = w_ff;
    if (phase_ff == SRSE_Q4 && alu_op && !dbit) begin
      nw = nxt_res;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w_ff <= SRSE_RST_W;
      flg_ff <= SRSE_RST_FLAGS;
    end else begin
      w_ff <= nw;
      // Push never reaches here, so flags hold on a push
      if (phase_ff == SRSE_Q4 && alu_op) begin
        flg_ff <= nxt_flg;
      end
    end
  end

  // File memory request: read in Q2; the write leaves at the end of Q4,
  // once the operand is in, and shows together with done
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fm_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      fm_ff.rd <= (phase_ff == SRSE_Q1) && ins_vld_i
               && (kind_dec != SRSE_K_PUSH) && (kind_dec != SRSE_K_NONE);
      fm_ff.wr <= (phase_ff == SRSE_Q4) && alu_op && dbit;
      fm_ff.addr <= addr;
      fm_ff.wdata <= nxt_res;
      done_ff <= (phase_ff == SRSE_Q4);
    end
  end

  // ==========================================================
  // Return stack
  srse_stack u_stack (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .push_i  (stk_push),
    .data_i  (pc_ff + SRSE_PC_STEP),
    .top_o   (top_of_return_stack_o),
    .level_o (stk_level_o)
  );

  assign fmem_o = fm_ff;
  assign w_o = w_ff;
  assign flags_o = flg_ff;
  assign phase_o = phase_ff;
  assign done_o = done_ff;

endmodule // srse_exec

// [verif/srse_exec_checker.sv]
// Port checker for the execution unit
module srse_exec_checker
  import srse_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic ins_vld_i, // Valid
  input wire logic [15:0] ins_i, // Word
  input wire logic [20:0] pc_i, // Address
  input wire srse_fmem_t fmem_o, // Memory
  input wire logic [4:0] flags_o, // Flags
  input wire logic [20:0] top_of_return_stack_o, // Top
  input wire logic [4:0] stk_level_o, // Depth
  input wire srse_phase_t phase_o, // Phase
  input wire logic done_o // Retire
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic tk;
  logic psh;
  assign tk = ins_vld_i && phase_o == SRSE_Q1;
  assign psh = tk && ins_i == SRSE_OP_PUSH;
  // ==========================================================
  // Assertions
  a_rd_in_q2: assert property (fmem_o.rd |-> phase_o == SRSE_Q2)
    else $error("file read outside second phase");
  a_wr_with_done: assert property (fmem_o.wr |-> done_o)
    else $error("write not at retire");
  a_phase_walk: assert property (phase_o == SRSE_Q2 |=>
    phase_o == SRSE_Q3 ##1 phase_o == SRSE_Q4 ##1 phase_o == SRSE_Q1)
    else $error("phase order broken");
  a_push_retire: assert property (psh |-> ##4 done_o)
    else $error("push not retired in four cycles");
  a_push_top: assert property (psh |-> ##2
    top_of_return_stack_o == $past(pc_i, 2) + SRSE_PC_STEP)
    else $error("pushed value wrong");
  a_push_depth: assert property (psh && stk_level_o < 5'h1F |-> ##2
    stk_level_o == $past(stk_level_o, 2) + 5'h01)
    else $error("depth not stepped");
  a_push_flags: assert property (psh |-> ##4
    flags_o == $past(flags_o, 4))
    else $error("push changed flags");
  a_rotl_carry: assert property (tk && ins_i[15:10] == SRSE_OP_RLNC
    |-> ##4 flags_o[SRSE_FLG_C] == $past(flags_o[SRSE_FLG_C], 4))
    else $error("rotate left touched carry");
  c_push: cover property (psh);
  c_subb: cover property (tk && ins_i[15:10] == SRSE_OP_SUBB);
  c_wr: cover property (fmem_o.wr);
endmodule // srse_exec_checker

bind srse_exec srse_exec_checker u_chk (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .ins_vld_i(ins_vld_i),
  .ins_i(ins_i),
  .pc_i(pc_i),
  .fmem_o(fmem_o),
  .flags_o(flags_o),
  .top_of_return_stack_o(top_of_return_stack_o),
  .stk_level_o(stk_level_o),
  .phase_o(phase_o),
  .done_o(done_o)
);

// [verif/srse_exec_test.sv]
// Self-checking bench of the execution unit
module srse_exec_test
  import srse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i;
  logic nrst_i;
  logic vld;
  logic [15:0] ins;
  logic [20:0] pc;
  logic [3:0] bank;
  logic ext;
  logic [11:0] fsr2;
  logic [7:0] frd;
  srse_fmem_t fmem;
  logic [7:0] w;
  logic [4:0] flags;
  logic [20:0] top;
  logic [4:0] lvl;
  srse_phase_t ph;
  logic done;
  logic [11:0] rd_addr;
  int n_fail;
  int comparisons;

  srse_exec uut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ins_vld_i(vld),
    .ins_i(ins),
    .pc_i(pc),
    .bank_select_register_i(bank),
    .ext_set_i(ext),
    .fsr2_i(fsr2),
    .frd_i(frd),
    .fmem_o(fmem),
    .w_o(w),
    .flags_o(flags),
    .top_of_return_stack_o(top),
    .stk_level_o(lvl),
    .phase_o(ph),
    .done_o(done)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(string nm, logic [20:0] seen, logic [20:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] op(logic [5:0] o, logic d, logic a,
                                     logic [7:0] f);
    return {o, d, a, f};
  endfunction

  // ==========================================================
  // One instruction; file data is held through the whole cycle
  task automatic run(logic [15:0] i, logic [7:0] f);
    int k;
    k = 0;
    while (ph !== SRSE_Q1 && k < 8) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 8) begin
      n_fail++;
      print_verdict();
    end
    ins = i;
    frd = f;
    vld = 1'b1;
    @(negedge clk_i);
    vld = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 8) begin
      if (fmem.rd === 1'b1) rd_addr = fmem.addr;
      @(negedge clk_i);
      k++;
    end
    if (k == 8) begin
      n_fail++;
      print_verdict();
    end
  endtask

  task automatic res(logic [7:0] ew, logic [4:0] ef, logic ewr,
                     logic [7:0] ed, logic [11:0] ea);
    chk("w", w, ew);
    chk("flags", flags, ef);
    chk("wr", fmem.wr, ewr);
    if (ewr) chk("wdata", fmem.wdata, ed);
    chk("addr", rd_addr, ea);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_rotate();
    chk("rst", {w, flags, ph}, 21'h0000);
    run(op(SRSE_OP_RRC, 1'b0, 1'b0, 8'h20), 8'h01);
    res(8'h00, 5'h05, 1'b0, 8'h00, 12'h020);
    run(op(SRSE_OP_RRC, 1'b1, 1'b0, 8'h21), 8'h03);
    res(8'h00, 5'h11, 1'b1, 8'h81, 12'h021);
    run(op(SRSE_OP_RLNC, 1'b0, 1'b0, 8'h22), 8'h86);
    res(8'h0D, 5'h01, 1'b0, 8'h00, 12'h022);
    $display("test rotate done");
  endtask

  task automatic t_subtract();
    run(op(SRSE_OP_SUBB, 1'b1, 1'b0, 8'h30), 8'h19);
    res(8'h0D, 5'h01, 1'b1, 8'h0C, 12'h030);
    bank = 4'h3;
    run(op(SRSE_OP_SUBB, 1'b0, 1'b1, 8'h03), 8'h03);
    res(8'hF6, 5'h10, 1'b0, 8'h00, 12'h303);
    ext = 1'b1;
    fsr2 = 12'h100;
    run(op(SRSE_OP_SUBB, 1'b1, 1'b0, 8'h10), 8'h7F);
    res(8'hF6, 5'h1A, 1'b1, 8'h88, 12'h110);
    run(op(SRSE_OP_RLNC, 1'b1, 1'b0, 8'h60), 8'h80);
    res(8'hF6, 5'h0A, 1'b1, 8'h01, 12'hF60);
    $display("test subtract done");
  endtask

  task automatic t_push();
    pc = 21'h0124;
    run(SRSE_OP_PUSH, 8'h00);
    chk("top", top, 21'h0126);
    chk("lvl", lvl, 21'h0001);
    chk("flags", flags, 21'h000A);
    pc = 21'h0300;
    run(SRSE_OP_PUSH, 8'h00);
    chk("top2", top, 21'h0302);
    chk("lvl2", lvl, 21'h0002);
    chk("w", w, 21'h00F6);
    $display("test push done");
  endtask

  initial begin
    n_fail = 0;
    comparisons = 0;
    nrst_i = 1'b0;
    vld = 1'b0;
    ins = 16'h0000;
    pc = 21'h0000;
    bank = 4'h0;
    ext = 1'b0;
    fsr2 = 12'h000;
    frd = 8'h00;
    rd_addr = 12'h000;
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    t_rotate();
    t_subtract();
    t_push();
    print_verdict();
  end
endmodule // srse_exec_test
